//--- indexed_port_watchdog_timer_test.sv
// Purpose: end-to-end test of the host controller driving the watchdog
// Assumes: SEC_CYCLES 20 and MIN_SECS 3 keep the run short
// Notes: a second device is driven raw to break the key rules
`timescale 1ns/10ps
module indexed_port_watchdog_timer_test
  import wdt_pkg::*;
;
  localparam int SC = 20;
  localparam int MS = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic kbd = 1'b0;
  logic mouse = 1'b0;
  logic mark = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, tmo, tmo_b;
  logic [31:0] hrdata, rd;
  logic [7:0] expq[$];
  logic [7:0] gotq[$];
  int seed = 32'hc0f0;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int t_ref = 0;
  io_port_if bus ();
  io_port_if bus_b ();
  wdt_host i_wdt_host (.CLOCK_I(clk), .NRST_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .port(bus));
  wdt_device #(.SEC_CYCLES(SC), .MIN_SECS(MS)) i_wdt_device (.CLOCK_I(clk), .NRST_I(rst_n),
    .KBD_ACT_I(kbd), .MOUSE_ACT_I(mouse), .TIMEOUT_O(tmo), .port(bus));
  wdt_device #(.SEC_CYCLES(SC), .MIN_SECS(MS)) i_wdt_device_b (.CLOCK_I(clk), .NRST_I(rst_n),
    .KBD_ACT_I(kbd), .MOUSE_ACT_I(mouse), .TIMEOUT_O(tmo_b), .port(bus_b));
  wdt_monitor i_wdt_monitor (.CLOCK_I(clk), .NRST_I(rst_n), .io_addr(bus.io_addr),
    .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_wdata(bus.io_wdata),
    .io_rdata(bus.io_rdata), .TIMEOUT_O(tmo));
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // latest data-port write is the reference for the countdown
  // an enabled activity pulse restarts the countdown as well
  always @(posedge clk) if ((bus.io_wr && bus.io_addr === DATA_PORT) || mark) t_ref <= cyc;
  always @(negedge clk)
    while (gotq.size() > 0)
    begin
      n_checks++;
      if (gotq.pop_front() !== expq.pop_front())
      begin
        miscompares++;
        $display("MISMATCH at %0t: result differs", $time);
      end
    end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bail();
    miscompares++;
    report_and_stop();
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    expq.push_back(e);
    gotq.push_back(g);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1 || hresp !== HRESP_OKAY) bail();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic cmd(input logic w, input logic [7:0] r, input logic [7:0] d);
    int n;
    ahb(1'b1, HOST_CMD_OFS, {15'h0, w, r, d});
    n = 0;
    do
    begin
      ahb(1'b0, HOST_STAT_OFS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 40);
    if (rd[0] !== 1'b0) bail();
  endtask
  task automatic rchk(input logic [7:0] r, input logic [7:0] e);
    cmd(1'b0, r, 8'h0);
    chk(e, rd[15:8]);
  endtask
  task automatic units(input int u, input logic [7:0] n);
    int k;
    k = 0;
    while (tmo !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    if (tmo !== 1'b1) bail();
    chk(n, 8'((cyc - t_ref) / u));
  endtask
  task automatic poke(input logic m, input logic en);
    @(posedge clk);
    kbd <= !m;
    mouse <= m;
    mark <= en;
    @(posedge clk);
    kbd <= 1'b0;
    mouse <= 1'b0;
    mark <= 1'b0;
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_b.io_wr <= w;
    bus_b.io_rd <= !w;
    bus_b.io_addr <= a;
    bus_b.io_wdata <= d;
    @(posedge clk);
    bus_b.io_wr <= 1'b0;
    bus_b.io_rd <= 1'b0;
    bus_b.io_wdata <= ~d;
  endtask
  task automatic io_chk(input logic [7:0] e);
    io(1'b0, DATA_PORT, 8'h0);
    @(posedge clk);
    #1;
    chk(e, bus_b.io_rdata);
  endtask
  initial
  begin
    logic [7:0] v;
    int i;
    bus_b.io_wr = 1'b0;
    bus_b.io_rd = 1'b0;
    bus_b.io_addr = IDX_PORT;
    bus_b.io_wdata = 8'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(posedge clk);
    rchk(REG_COUNT, BYTE_RST);
    rchk(REG_UNIT, BYTE_RST);
    rchk(REG_ACT, BYTE_RST);
    rchk(REG_CTRL, BYTE_RST);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      cmd(1'b1, i[0] ? REG_COUNT : REG_UNIT, v);
      rchk(i[0] ? REG_COUNT : REG_UNIT, v);
    end
    cmd(1'b1, REG_UNIT, 8'h00);
    cmd(1'b1, REG_COUNT, 8'h01);
    repeat (3 * SC) @(posedge clk);
    chk(8'h0, {7'h0, tmo});
    $display("test registers done");
    // stop the count first so no expiry can race the reload below
    cmd(1'b1, REG_COUNT, 8'h00);
    cmd(1'b1, REG_ACT, 8'h01);
    cmd(1'b1, REG_COUNT, 8'h03);
    units(SC, 8'h03);
    rchk(REG_CTRL, 8'h10);
    cmd(1'b1, REG_COUNT, 8'h02);
    chk(8'h0, {7'h0, tmo});
    cmd(1'b1, REG_COUNT, 8'h02);
    units(SC, 8'h02);
    cmd(1'b1, REG_UNIT, 8'h08);
    cmd(1'b1, REG_COUNT, 8'h01);
    units(SC * MS, 8'h01);
    cmd(1'b1, REG_UNIT, 8'h00);
    $display("test countdown done");
    // enabled keyboard, enabled mouse, then both disabled
    for (i = 0; i < 4; i++)
    begin
      cmd(1'b1, REG_CTRL, i[1] ? 8'h00 : (i[0] ? 8'h80 : 8'h40));
      cmd(1'b1, REG_COUNT, 8'h02);
      repeat (25) @(posedge clk);
      poke(i[0], !i[1]);
      units(SC, 8'h02);
    end
    $display("test activity done");
    cmd(1'b1, REG_COUNT, 8'h00);
    repeat (3 * SC) @(posedge clk);
    chk(8'h0, {7'h0, tmo});
    cmd(1'b1, REG_CTRL, 8'h20);
    chk(8'h1, {7'h0, tmo});
    rchk(REG_CTRL, 8'h10);
    cmd(1'b1, REG_ACT, 8'h00);
    chk(8'h0, {7'h0, tmo});
    $display("test force done");
    io(1'b1, IDX_PORT, REG_COUNT);
    io(1'b1, DATA_PORT, 8'h55);
    io_chk(LOCKED_READ);
    io(1'b1, IDX_PORT, KEY_UNLOCK);
    io(1'b1, IDX_PORT, KEY_UNLOCK);
    io(1'b1, IDX_PORT, REG_LDEV);
    io(1'b1, DATA_PORT, LDEV_WDT);
    io(1'b1, IDX_PORT, REG_COUNT);
    io_chk(BYTE_RST);
    io(1'b1, IDX_PORT, KEY_LOCK);
    io_chk(LOCKED_READ);
    chk(8'h0, {7'h0, tmo_b});
    $display("test raw port done");
    @(posedge clk);
    @(negedge clk);
    #1;
    report_and_stop();
  end
endmodule // indexed_port_watchdog_timer_test

//--- io_port_if.sv
// Purpose: host I/O cycle carrier between controller and watchdog
// Assumes: one-cycle strobes, read data valid the cycle after the strobe
// Notes: no tristate; read data is a plain device output
`timescale 1ns/10ps
interface io_port_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  modport device (input io_addr, input io_wr, input io_rd, input io_wdata, output io_rdata);
  modport host (output io_addr, output io_wr, output io_rd, output io_wdata, input io_rdata);
endinterface

//--- wdt_device.sv
// Purpose: watchdog reached through index/data I/O ports
// Assumes: strobes synchronous to CLOCK_I, one cycle each
// Notes: timeout output is a level until restrobe or disable
//
// Design decision made here: register access over the index/data I/O ports.
`timescale 1ns/10ps
module wdt_device
  import wdt_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES,
  parameter int MIN_SECS = SECS_PER_MIN
)
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic KBD_ACT_I,
  input wire logic MOUSE_ACT_I,
  output logic TIMEOUT_O,
  io_port_if.device port
);

  // configuration group
  logic key_seen_ff, nxt_key_seen;
  logic unlocked_ff, nxt_unlocked;
  logic [7:0] index_ff, nxt_index;
  logic [7:0] ldev_ff, nxt_ldev;
  logic [7:0] act_ff, nxt_act;
  logic [7:0] unit_ff, nxt_unit;
  logic [7:0] count_ff, nxt_count;
  logic kbd_en_ff, nxt_kbd_en;
  logic mouse_en_ff, nxt_mouse_en;
  logic [7:0] rdata_ff, nxt_rdata;
  logic idx_wr, data_wr, data_rd, wdt_sel;
  logic count_wr, force_wr;

  // timer group
  logic [31:0] sec_cnt_ff, nxt_sec_cnt;
  logic [7:0] min_cnt_ff, nxt_min_cnt;
  logic [7:0] run_cnt_ff, nxt_run_cnt;
  logic timeout_ff, nxt_timeout;
  logic enabled, restrobe, sec_tick, min_tick, unit_tick, expire;

  assign idx_wr = port.io_wr && (port.io_addr == IDX_PORT); // [RL4]
  assign data_wr = port.io_wr && (port.io_addr == DATA_PORT) && unlocked_ff; // [RL4] [RL18]
  assign data_rd = port.io_rd && (port.io_addr == DATA_PORT);
  assign wdt_sel = (ldev_ff == LDEV_WDT); // [RL8]
  assign count_wr = data_wr && wdt_sel && (index_ff == REG_COUNT);
  assign force_wr = data_wr && wdt_sel && (index_ff == REG_CTRL)
    && port.io_wdata[CTRL_FORCE_BIT];
  assign enabled = act_ff[ACT_ON_BIT]; // [RL9]

  always_comb
  begin
    nxt_key_seen = key_seen_ff;
    nxt_unlocked = unlocked_ff;
    nxt_index = index_ff;
    nxt_ldev = ldev_ff;
    nxt_act = act_ff;
    nxt_unit = unit_ff;
    nxt_count = count_ff;
    nxt_kbd_en = kbd_en_ff;
    nxt_mouse_en = mouse_en_ff;
    nxt_rdata = rdata_ff;
    if (idx_wr)
    begin
      if (!unlocked_ff)
      begin
        // any other index byte breaks the pair, so stray traffic cannot unlock
        if (port.io_wdata == KEY_UNLOCK)
        begin
          nxt_unlocked = key_seen_ff; // [RL6]
          nxt_key_seen = !key_seen_ff;
        end
        else
        begin
          nxt_key_seen = 1'b0; // [RL6]
        end
      end
      else if (port.io_wdata == KEY_LOCK)
      begin
        nxt_unlocked = 1'b0; // [RL7]
        nxt_key_seen = 1'b0;
      end
      else
      begin
        nxt_index = port.io_wdata; // [RL4]
      end
    end
    if (data_wr)
    begin
      if (index_ff == REG_LDEV)
      begin
        nxt_ldev = port.io_wdata; // [RL8]
      end
      else if (wdt_sel)
      begin
        case (index_ff)
          REG_ACT: nxt_act = port.io_wdata; // [RL9] [RL1]
          REG_UNIT: nxt_unit = port.io_wdata; // [RL10]
          REG_COUNT: nxt_count = port.io_wdata; // [RL11]
          REG_CTRL:
          begin
            nxt_kbd_en = port.io_wdata[CTRL_KBD_BIT]; // [RL13]
            nxt_mouse_en = port.io_wdata[CTRL_MOUSE_BIT]; // [RL16]
          end
          default: nxt_act = act_ff;
        endcase
      end
    end
    if (data_rd)
    begin
      if (!unlocked_ff)
      begin
        nxt_rdata = LOCKED_READ;
      end
      else if (index_ff == REG_LDEV)
      begin
        nxt_rdata = ldev_ff;
      end
      else if (!wdt_sel)
      begin
        nxt_rdata = LOCKED_READ;
      end
      else
      begin
        case (index_ff)
          REG_ACT: nxt_rdata = act_ff;
          REG_UNIT: nxt_rdata = unit_ff;
          REG_COUNT: nxt_rdata = count_ff;
          REG_CTRL:
          begin
            // force bit always reads back zero since it acts only on the write
            nxt_rdata = BYTE_RST;
            nxt_rdata[CTRL_MOUSE_BIT] = mouse_en_ff;
            nxt_rdata[CTRL_KBD_BIT] = kbd_en_ff;
            nxt_rdata[CTRL_STAT_BIT] = timeout_ff; // [RL15] [RL14]
          end
          default: nxt_rdata = BYTE_RST;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      key_seen_ff <= 1'b0;
      unlocked_ff <= 1'b0;
      index_ff <= BYTE_RST;
      ldev_ff <= BYTE_RST;
      act_ff <= BYTE_RST; // [RL9]
      unit_ff <= BYTE_RST; // [RL10]
      count_ff <= BYTE_RST; // [RL11]
      kbd_en_ff <= 1'b0; // [RL13]
      mouse_en_ff <= 1'b0;
      rdata_ff <= BYTE_RST;
    end
    else
    begin
      key_seen_ff <= nxt_key_seen;
      unlocked_ff <= nxt_unlocked;
      index_ff <= nxt_index;
      ldev_ff <= nxt_ldev;
      act_ff <= nxt_act;
      unit_ff <= nxt_unit;
      count_ff <= nxt_count;
      kbd_en_ff <= nxt_kbd_en;
      mouse_en_ff <= nxt_mouse_en;
      rdata_ff <= nxt_rdata;
    end
  end

  // timer: prescaler restarts on every strobe so the full period is granted
  assign restrobe = count_wr
    || (kbd_en_ff && KBD_ACT_I) // [RL13]
    || (mouse_en_ff && MOUSE_ACT_I); // [RL16] [RL12]
  assign sec_tick = (sec_cnt_ff == 32'(SEC_CYCLES - 1)); // [RL17]
  assign min_tick = sec_tick && (min_cnt_ff == 8'(MIN_SECS - 1)); // [RL17]
  assign unit_tick = unit_ff[UNIT_MIN_BIT] ? min_tick : sec_tick; // [RL10] [RL2]
  assign expire = enabled && (count_ff != BYTE_RST) && !timeout_ff
    && unit_tick && (run_cnt_ff == 8'h01); // [RL3] [RL11]

  always_comb
  begin
    nxt_sec_cnt = sec_tick ? 32'h0000_0000 : sec_cnt_ff + 32'h0000_0001;
    nxt_min_cnt = min_cnt_ff;
    nxt_run_cnt = run_cnt_ff;
    nxt_timeout = timeout_ff;
    if (sec_tick)
    begin
      nxt_min_cnt = min_tick ? 8'h00 : min_cnt_ff + 8'h01;
    end
    if (enabled && unit_tick && (run_cnt_ff != 8'h00) && !timeout_ff)
    begin
      nxt_run_cnt = run_cnt_ff - 8'h01; // [RL17]
    end
    if (restrobe)
    begin
      nxt_sec_cnt = 32'h0000_0000;
      nxt_min_cnt = 8'h00;
      nxt_run_cnt = count_wr ? port.io_wdata : count_ff; // [RL12]
      nxt_timeout = 1'b0;
    end
    // drop the output on the very edge that turns the function off, not one later
    if (!enabled || !nxt_act[ACT_ON_BIT])
    begin
      nxt_timeout = 1'b0; // [RL1]
    end
    // a fresh expiry or force wins over a same-cycle restrobe
    if (enabled && nxt_act[ACT_ON_BIT] && (expire || force_wr))
    begin
      nxt_timeout = 1'b1; // [RL3] [RL14] [RL1]
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sec_cnt_ff <= 32'h0000_0000;
      min_cnt_ff <= 8'h00;
      run_cnt_ff <= BYTE_RST;
      timeout_ff <= 1'b0;
    end
    else
    begin
      sec_cnt_ff <= nxt_sec_cnt;
      min_cnt_ff <= nxt_min_cnt;
      run_cnt_ff <= nxt_run_cnt;
      timeout_ff <= nxt_timeout;
    end
  end

  assign TIMEOUT_O = timeout_ff; // [RL3]
  assign port.io_rdata = rdata_ff;

endmodule // wdt_device

//--- wdt_host.sv
// Purpose: AHB-Lite driven controller that runs the port key sequence
// Assumes: single word transfers, zero wait states
// Notes: a command while busy is dropped; poll busy first
`timescale 1ns/10ps
module wdt_host
  import wdt_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  io_port_if.host port
);

  logic wr_pend_ff, nxt_wr_pend;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [7:0] reg_ff, nxt_reg;
  logic [7:0] val_ff, nxt_val;
  logic is_write_ff, nxt_is_write;
  logic [7:0] result_ff, nxt_result;
  logic [2:0] step_ff, nxt_step;
  host_state_e state_ff, nxt_state;
  logic [15:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [7:0] wdata_ff, nxt_wdata;
  logic addr_ok;

  // step table: unlock pair, select, index, data, relock
  function automatic logic [17:0] step_op(input logic [2:0] s, input logic [7:0] r,
                                          input logic [7:0] v, input logic w);
    logic [17:0] op;
    op = 18'h0;
    case (s)
      3'h0, 3'h1: op = {1'b1, 1'b0, 8'h00, KEY_UNLOCK}; // [RL6]
      3'h2: op = {1'b1, 1'b0, 8'h00, REG_LDEV}; // [RL5]
      3'h3: op = {1'b1, 1'b1, 8'h00, LDEV_WDT}; // [RL8]
      3'h4: op = {1'b1, 1'b0, 8'h00, r}; // [RL5]
      3'h5: op = {w, 1'b1, 8'h00, v};
      default: op = {1'b1, 1'b0, 8'h00, KEY_LOCK}; // [RL7]
    endcase
    return op;
  endfunction

  assign addr_ok = HSEL_I && HREADY_I && (HTRANS_I == HTRANS_NONSEQ);

  always_comb
  begin
    logic [17:0] op;
    op = step_op(3'h0, reg_ff, val_ff, is_write_ff);
    nxt_wr_pend = addr_ok && HWRITE_I && (HADDR_I == HOST_CMD_OFS);
    nxt_hrdata = hrdata_ff;
    nxt_reg = reg_ff;
    nxt_val = val_ff;
    nxt_is_write = is_write_ff;
    nxt_result = result_ff;
    nxt_step = step_ff;
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_wdata = wdata_ff;
    if (addr_ok && !HWRITE_I)
    begin
      nxt_hrdata = (HADDR_I == HOST_STAT_OFS)
        ? {16'h0000, result_ff, 7'h00, (state_ff != ST_IDLE)} : 32'h0000_0000;
    end
    case (state_ff)
      ST_IDLE:
      begin
        if (wr_pend_ff)
        begin
          nxt_reg = HWDATA_I[15:8];
          nxt_val = HWDATA_I[7:0];
          nxt_is_write = HWDATA_I[CMD_WRITE_BIT];
          nxt_step = 3'h0;
          nxt_state = ST_DRIVE;
          nxt_addr = IDX_PORT; // [RL6]
          nxt_wr = 1'b1;
          nxt_wdata = KEY_UNLOCK;
        end
      end
      ST_DRIVE: nxt_state = ST_SETTLE;
      ST_SETTLE:
      begin
        if (step_ff == HOST_DATA_STEP && !is_write_ff)
        begin
          nxt_result = port.io_rdata;
        end
        if (step_ff == HOST_LAST_STEP)
        begin
          nxt_state = ST_IDLE;
        end
        else
        begin
          op = step_op(step_ff + 3'h1, reg_ff, val_ff, is_write_ff);
          nxt_step = step_ff + 3'h1;
          nxt_state = ST_DRIVE;
          nxt_addr = op[16] ? DATA_PORT : IDX_PORT; // [RL4]
          nxt_wr = op[17];
          nxt_rd = !op[17];
          nxt_wdata = op[7:0];
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wr_pend_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      reg_ff <= BYTE_RST;
      val_ff <= BYTE_RST;
      is_write_ff <= 1'b0;
      result_ff <= BYTE_RST;
      step_ff <= 3'h0;
      state_ff <= ST_IDLE;
      addr_ff <= IDX_PORT;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      wdata_ff <= BYTE_RST;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      hrdata_ff <= nxt_hrdata;
      reg_ff <= nxt_reg;
      val_ff <= nxt_val;
      is_write_ff <= nxt_is_write;
      result_ff <= nxt_result;
      step_ff <= nxt_step;
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      wdata_ff <= nxt_wdata;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = HRESP_OKAY;
  assign HRDATA_O = hrdata_ff;
  assign port.io_addr = addr_ff;
  assign port.io_wr = wr_ff;
  assign port.io_rd = rd_ff;
  assign port.io_wdata = wdata_ff;

endmodule // wdt_host

//--- wdt_monitor.sv
// Purpose: protocol checks on the host to watchdog port
// Assumes: host spaces its strobes two cycles apart
// Notes: lock state, index and a few registers are shadowed here
`timescale 1ns/10ps
module wdt_monitor
  import wdt_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic TIMEOUT_O
);
  logic key_ff, open_ff, act_ff;
  logic [7:0] idx_ff, ldev_ff, cnt_ff;
  wire logic iw = io_wr && io_addr == IDX_PORT;
  wire logic dw = io_wr && io_addr == DATA_PORT && open_ff;
  wire logic dr = io_rd && io_addr == DATA_PORT && open_ff;
  wire logic wd = dw && ldev_ff == LDEV_WDT;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  always_ff @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      {key_ff, open_ff, act_ff} <= 3'h0;
      {idx_ff, ldev_ff, cnt_ff} <= 24'h0;
    end
    else
    begin
      if (iw)
        key_ff <= io_wdata == KEY_UNLOCK && !key_ff && !open_ff;
      // one compare serves unlock and relock, key_ff is low while open
      if (iw && io_wdata == (open_ff ? KEY_LOCK : KEY_UNLOCK))
        open_ff <= key_ff;
      if (iw && open_ff && io_wdata != KEY_LOCK)
        idx_ff <= io_wdata;
      if (dw && idx_ff == REG_LDEV)
        ldev_ff <= io_wdata;
      if (wd && idx_ff == REG_ACT)
        act_ff <= io_wdata[ACT_ON_BIT];
      if (wd && idx_ff == REG_COUNT)
        cnt_ff <= io_wdata;
    end
  end
  sequence key_pair;
    iw && io_wdata == KEY_UNLOCK ##2 iw && io_wdata == KEY_UNLOCK;
  endsequence
  sequence pick_wdt;
    iw && io_wdata == REG_LDEV ##2 dw && io_wdata == LDEV_WDT;
  endsequence
  a_unlock_order:
    assert property (iw && io_wdata == KEY_UNLOCK && !open_ff && !key_ff |-> key_pair ##2 pick_wdt)
    else $error("key pair or select out of order");
  a_index_first:
    assert property ((io_wr || io_rd) && io_addr == DATA_PORT |-> $past(iw, 2))
    else $error("data access without index write");
  a_relock_end:
    assert property ((dw || dr) && idx_ff != REG_LDEV |-> ##2 iw && io_wdata == KEY_LOCK)
    else $error("no relock after data step");
  a_rdata_holds:
    assert property (!(io_rd && io_addr == DATA_PORT) |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_count_back:
    assert property (dr && ldev_ff == LDEV_WDT && idx_ff == REG_COUNT |=> io_rdata == cnt_ff)
    else $error("count register read back wrong");
  a_force_fires:
    assert property (wd && idx_ff == REG_CTRL && io_wdata[CTRL_FORCE_BIT] && act_ff |=> TIMEOUT_O)
    else $error("forced timeout missing");
  a_off_quiet:
    assert property (!act_ff |-> !TIMEOUT_O)
    else $error("timeout while disabled");
  a_reload_clears:
    assert property (wd && idx_ff == REG_COUNT && act_ff |=> !TIMEOUT_O)
    else $error("count write did not clear timeout");
endmodule // wdt_monitor

//--- wdt_pkg.sv
// Purpose: shared constants for the indexed-port watchdog and its host controller
// Assumes: one 10 MHz clock shared by both ends
// Notes: How it works list below
//
// How it works
// RL1: software switches the timer; off means no timeout
// RL2: period is 1 to 255 seconds or minutes
// RL3: expiry raises the timeout output
// RL4: index port 2E, data port 2F
// RL5: host writes index before each data access
// RL6: two 87 writes to index unlock access
// RL7: AA written to index relocks access
// RL8: 08 into index 07 maps watchdog registers
// RL9: 01 at index 30 enables; reset disabled
// RL10: F5 bit 3 picks minutes, reset seconds
// RL11: F6 holds count; zero stops, reset zero
// RL12: writing F6 restarts countdown from value
// RL13: F7 bit 6 lets keyboard restrobe
// RL14: F7 bit 5 forces timeout, self-clears
// RL15: F7 bit 4 reads timeout status
// RL16: F7 bit 7 lets mouse restrobe
// RL17: one-second and one-minute ticks from clock
// RL18: data writes ignored while locked
package wdt_pkg;
  localparam logic [15:0] IDX_PORT = 16'h002e;
  localparam logic [15:0] DATA_PORT = 16'h002f;
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK = 8'haa;
  localparam logic [7:0] REG_LDEV = 8'h07;
  localparam logic [7:0] REG_ACT = 8'h30;
  localparam logic [7:0] REG_UNIT = 8'hf5;
  localparam logic [7:0] REG_COUNT = 8'hf6;
  localparam logic [7:0] REG_CTRL = 8'hf7;
  localparam logic [7:0] LDEV_WDT = 8'h08;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] LOCKED_READ = 8'hff;
  localparam int ACT_ON_BIT = 0;
  localparam int UNIT_MIN_BIT = 3;
  localparam int CTRL_MOUSE_BIT = 7;
  localparam int CTRL_KBD_BIT = 6;
  localparam int CTRL_FORCE_BIT = 5;
  localparam int CTRL_STAT_BIT = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SECOND_NS = 1000000000;
  localparam int SECOND_CYCLES = (SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECS_PER_MIN = 60;
  localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
  localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0004;
  localparam int CMD_WRITE_BIT = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [2:0] HOST_LAST_STEP = 3'h6;
  localparam logic [2:0] HOST_DATA_STEP = 3'h5;
  typedef enum {ST_IDLE, ST_DRIVE, ST_SETTLE} host_state_e;
endpackage
